// [include/ccdic_regs.svh]
// Constants of the cascaded dual interrupt controller: I/O addresses,
// command word bit positions, command codes and reset values.
// Assumes inclusion by bare name from the design files.
`ifndef CCDIC_REGS_SVH
`define CCDIC_REGS_SVH

// I/O addresses of the two controllers
`define CCDIC_MASTER_EVEN   16'h0020
`define CCDIC_MASTER_ODD    16'h0021
`define CCDIC_SLAVE_EVEN    16'h00A0
`define CCDIC_SLAVE_ODD     16'h00A1
`define CCDIC_UNMAPPED_RD   8'h00

// Even address write: word selection bits
`define CCDIC_INIT_BIT      4
`define CCDIC_OCW_SEL_BIT   3

// Init start word fields
`define CCDIC_LEVEL_BIT     3
`define CCDIC_SINGLE_BIT    1
`define CCDIC_NEED_MODE_BIT 0

// Mode word field
`define CCDIC_AUTO_EOS_BIT  1

// Read select word fields
`define CCDIC_ESMM_BIT      6
`define CCDIC_SMM_BIT       5
`define CCDIC_RR_BIT        1
`define CCDIC_RIS_BIT       0

// Rotation and end of service command codes, data bits 7 to 5
`define CCDIC_OP_ROT_AEOS_CLR 3'h0
`define CCDIC_OP_NS_EOS       3'h1
`define CCDIC_OP_NOP          3'h2
`define CCDIC_OP_SP_EOS       3'h3
`define CCDIC_OP_ROT_AEOS_SET 3'h4
`define CCDIC_OP_ROT_NS_EOS   3'h5
`define CCDIC_OP_SET_PRIO     3'h6
`define CCDIC_OP_ROT_SP_EOS   3'h7

// Channel numbers and reset values
`define CCDIC_CASC_CHAN     3'h2
`define CCDIC_SPUR_CHAN     3'h7
`define CCDIC_LOWEST_RST    3'h7
`define CCDIC_SLAVE_ID_RST  8'h07
`define CCDIC_MASTER_CASC   8'h04

`endif

// [include/ccdic_pkg.sv]
// Types of the cascaded dual interrupt controller.
// Assumes no other package; constants live in ccdic_regs.svh.
package ccdic_pkg;

  // Init word sequence, Gray coded along the usual path
  typedef enum logic [1:0] {
    CCDIC_ICW_IDLE = 2'h0,
    CCDIC_ICW_VEC  = 2'h1,
    CCDIC_ICW_CASC = 2'h3,
    CCDIC_ICW_MODE = 2'h2
  } ccdic_icw_e;

  // Register port request from the processor side
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ccdic_io_req_s;

  // State of one controller
  typedef struct packed {
    logic [7:0]  pending_request_reg;
    logic [7:0]  in_service_reg;
    logic [7:0]  channel_mask_reg;
    logic [7:0]  in_d;
    logic [4:0]  vbase;
    logic [7:0]  casc;
    logic [2:0]  lowest;
    ccdic_icw_e  icw;
    logic        single;
    logic        need_mode;
    logic        level;
    logic        auto_eos;
    logic        rot_auto;
    logic        smm;
    logic        rd_isr;
    logic        ack_valid;
    logic        ack_spur;
    logic        ack_casc;
    logic [2:0]  ack_chan;
  } ccdic_state_s;

endpackage

// [rtl/ccdic_prio.sv]
// Priority resolver of one controller: finds the highest priority set bit.
// Assumes top is the channel that currently holds the highest priority.
`timescale 1ns/10ps

module ccdic_prio (
  // Request vector and rotation
  input  wire logic [7:0] req,
  input  wire logic [2:0] top,
  // Result
  output logic            found,
  output logic [2:0]      chan,
  output logic [2:0]      rank
);

  logic [7:0] rot;

  // Rotate so that the top channel sits at rank zero, then pick the first
  always_comb begin
    rot   = 8'h00;
    found = 1'b0;
    rank  = 3'h0;
    for (int i = 0; i < 8; i++) begin
      rot[i] = req[3'(i) + top];
    end
    for (int i = 7; i >= 0; i--) begin
      if (rot[i]) begin
        found = 1'b1;
        rank  = 3'(i);
      end
    end
  end

  // Map rank back to channel number
  assign chan = rank + top;

endmodule // ccdic_prio

// [rtl/ccdic_top.sv]
// Cascaded pair of interrupt controllers giving 15 request channels.
// Assumes register port strobes and acknowledge strobes on clock;
// request lines arrive asynchronously and are synchronised here.
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "ccdic_regs.svh"

module ccdic_top (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Register port
  input  wire ccdic_pkg::ccdic_io_req_s io_req,
  output logic [7:0]                    rdata_ff,
  // Request sources
  input  wire logic                     timer0_output,
  input  wire logic                     rtc_irq,
  input  wire logic                     irq1,
  input  wire logic [4:0]               irq3_7,
  input  wire logic [6:0]               irq9_15,
  // Processor interrupt and acknowledge
  output logic                          cpu_intr,
  input  wire logic                     iack_first,
  input  wire logic                     iack_second,
  // Peripheral data bus, vector drive
  output logic [7:0]                    periph_data_ff,
  output logic                          periph_data_oe_n_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Shared decoding

  // Exact I/O address match
  function automatic logic io_hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Request synchronisers

  logic [15:0] raw_irq;
  logic [15:0] sync1_ff;
  logic [15:0] sync2_ff;
  logic [1:0]  int_w;
  logic [2:0]  pch_w [2];
  logic [7:0]  casc_w [2];
  logic [1:0]  drive_w;
  logic [7:0]  vec_w [2];
  logic [1:0]  hit_w;
  logic [7:0]  rd_w [2];
  logic        casc_act;

  // Source map, channel 2 of the master is internal
  assign raw_irq = {irq9_15, rtc_irq, irq3_7, 1'b0, irq1, timer0_output};

  // Two flops before any logic reads a pin
  always_ff @(posedge clock) begin
    if (rst) begin
      sync1_ff <= 16'h0000;
      sync2_ff <= 16'h0000;
    end else begin
      sync1_ff <= raw_irq;
      sync2_ff <= sync1_ff;
    end
  end

  // Master takes the cascade path when its winner has a slave behind it
  assign casc_act = int_w[0] && casc_w[0][pch_w[0]];
  assign cpu_intr = int_w[0];

  ////////////////////////////////////////////////////////////////////////
  // Two controllers

  for (genvar gi = 0; gi < 2; gi++) begin : g_ctl
    ccdic_pkg::ccdic_state_s st_ff;
    ccdic_pkg::ccdic_state_s nxt_st;
    logic [7:0] chan_in;
    logic [7:0] eff_isr;
    logic [2:0] top;
    logic       pf;
    logic       isf;
    logic [2:0] pch;
    logic [2:0] prk;
    logic [2:0] ich;
    logic [2:0] irk;
    logic       sel_even;
    logic       sel_odd;
    logic       mine;
    logic       spur;

    // Channel inputs; slave output lands on master channel 2
    if (gi == 0) begin : g_master
      assign chan_in  = {sync2_ff[7:3], int_w[1], sync2_ff[1:0]};
      assign sel_even = io_hit(io_req.addr, `CCDIC_MASTER_EVEN);
      assign sel_odd  = io_hit(io_req.addr, `CCDIC_MASTER_ODD);
      assign mine     = 1'b1;
    end else begin : g_slave
      assign chan_in  = sync2_ff[15:8];
      assign sel_even = io_hit(io_req.addr, `CCDIC_SLAVE_EVEN);
      assign sel_odd  = io_hit(io_req.addr, `CCDIC_SLAVE_ODD);
      assign mine     = casc_act && (st_ff.casc[2:0] == pch_w[0]);
    end

    // Priority: top channel follows the lowest one
    assign top     = st_ff.lowest + 3'h1;
    assign eff_isr = st_ff.smm ? (st_ff.in_service_reg & ~st_ff.channel_mask_reg) : st_ff.in_service_reg;

    ccdic_prio u_pend (
      .req   (st_ff.pending_request_reg & ~st_ff.channel_mask_reg),
      .top   (top),
      .found (pf),
      .chan  (pch),
      .rank  (prk)
    );

    ccdic_prio u_serv (
      .req   (eff_isr),
      .top   (top),
      .found (isf),
      .chan  (ich),
      .rank  (irk)
    );

    // Request qualifies only above every channel in service, except masked ones in special mask mode
    assign int_w[gi]  = pf && (!isf || (prk < irk));
    assign spur       = !int_w[gi];
    assign pch_w[gi]  = pch;
    assign casc_w[gi] = st_ff.casc;

    // Vector on second acknowledge; master yields when cascaded
    assign drive_w[gi] = iack_second && st_ff.ack_valid && !st_ff.ack_casc;
    assign vec_w[gi]   = {st_ff.vbase, st_ff.ack_chan};

    // Read port answers
    assign hit_w[gi] = sel_even || sel_odd;
    assign rd_w[gi]  = sel_odd ? st_ff.channel_mask_reg : (st_ff.rd_isr ? st_ff.in_service_reg : st_ff.pending_request_reg);

    // Next state of one controller
    always_comb begin
      nxt_st      = st_ff;
      nxt_st.in_d = chan_in;
      // Edge or level latching; a withdrawn line drops its request
      if (st_ff.level) begin
        nxt_st.pending_request_reg = chan_in;
      end else begin
        nxt_st.pending_request_reg = (st_ff.pending_request_reg | (chan_in & ~st_ff.in_d)) & chan_in;
      end
      // First acknowledge: winner goes in service
      if (iack_first && mine) begin
        nxt_st.ack_valid = 1'b1;
        nxt_st.ack_spur  = spur;
        nxt_st.ack_chan  = spur ? `CCDIC_SPUR_CHAN : pch;
        nxt_st.ack_casc  = (gi == 0) && casc_act;
        if (!spur) begin
          nxt_st.in_service_reg[pch] = 1'b1;
          nxt_st.pending_request_reg[pch] = 1'b0;
        end
      end
      // Second acknowledge closes the cycle, optional automatic end
      if (iack_second && st_ff.ack_valid) begin
        nxt_st.ack_valid = 1'b0;
        if (st_ff.auto_eos && !st_ff.ack_spur) begin
          nxt_st.in_service_reg[st_ff.ack_chan] = 1'b0;
          if (st_ff.rot_auto) begin
            nxt_st.lowest = st_ff.ack_chan;
          end
        end
      end
      // Even address writes
      if (io_req.wr && sel_even) begin
        if (io_req.wdata[`CCDIC_INIT_BIT]) begin
          nxt_st.icw       = ccdic_pkg::CCDIC_ICW_VEC;
          nxt_st.level     = io_req.wdata[`CCDIC_LEVEL_BIT];
          nxt_st.single    = io_req.wdata[`CCDIC_SINGLE_BIT];
          nxt_st.need_mode = io_req.wdata[`CCDIC_NEED_MODE_BIT];
          nxt_st.channel_mask_reg       = 8'h00;
          nxt_st.lowest    = `CCDIC_LOWEST_RST;
          nxt_st.rot_auto  = 1'b0;
          nxt_st.auto_eos  = 1'b0;
          nxt_st.smm       = 1'b0;
          nxt_st.rd_isr    = 1'b0;
          nxt_st.casc      = (gi == 0) ? st_ff.casc : `CCDIC_SLAVE_ID_RST;
        end else if (io_req.wdata[`CCDIC_OCW_SEL_BIT]) begin
          nxt_st.icw = ccdic_pkg::CCDIC_ICW_IDLE;
          if (io_req.wdata[`CCDIC_ESMM_BIT]) begin
            nxt_st.smm = io_req.wdata[`CCDIC_SMM_BIT];
          end
          if (io_req.wdata[`CCDIC_RR_BIT]) begin
            nxt_st.rd_isr = io_req.wdata[`CCDIC_RIS_BIT];
          end
        end else begin
          nxt_st.icw = ccdic_pkg::CCDIC_ICW_IDLE;
          case (io_req.wdata[7:5])
            `CCDIC_OP_NS_EOS, `CCDIC_OP_ROT_NS_EOS: begin
              if (isf) begin
                nxt_st.in_service_reg[ich] = 1'b0;
                if (io_req.wdata[7] || st_ff.rot_auto) begin
                  nxt_st.lowest = ich;
                end
              end
            end
            `CCDIC_OP_SP_EOS, `CCDIC_OP_ROT_SP_EOS: begin
              nxt_st.in_service_reg[io_req.wdata[2:0]] = 1'b0;
              if (io_req.wdata[7] || st_ff.rot_auto) begin
                nxt_st.lowest = io_req.wdata[2:0];
              end
            end
            `CCDIC_OP_SET_PRIO:     nxt_st.lowest = io_req.wdata[2:0];
            `CCDIC_OP_ROT_AEOS_SET: nxt_st.rot_auto = 1'b1;
            `CCDIC_OP_ROT_AEOS_CLR: nxt_st.rot_auto = 1'b0;
            default:                nxt_st.rot_auto = st_ff.rot_auto;
          endcase
        end
      end
      // Odd address writes: init sequence or mask
      if (io_req.wr && sel_odd) begin
        case (st_ff.icw)
          ccdic_pkg::CCDIC_ICW_VEC: begin
            nxt_st.vbase = io_req.wdata[7:3];
            if (!st_ff.single) begin
              nxt_st.icw = ccdic_pkg::CCDIC_ICW_CASC;
            end else if (st_ff.need_mode) begin
              nxt_st.icw = ccdic_pkg::CCDIC_ICW_MODE;
            end else begin
              nxt_st.icw = ccdic_pkg::CCDIC_ICW_IDLE;
            end
          end
          ccdic_pkg::CCDIC_ICW_CASC: begin
            nxt_st.casc = io_req.wdata;
            nxt_st.icw  = st_ff.need_mode ? ccdic_pkg::CCDIC_ICW_MODE
                                          : ccdic_pkg::CCDIC_ICW_IDLE;
          end
          ccdic_pkg::CCDIC_ICW_MODE: begin
            nxt_st.auto_eos = io_req.wdata[`CCDIC_AUTO_EOS_BIT];
            nxt_st.icw      = ccdic_pkg::CCDIC_ICW_IDLE;
          end
          default: nxt_st.channel_mask_reg = io_req.wdata;
        endcase
      end
      // Acknowledge set wins over an end command in the same cycle
      if (iack_first && mine && !spur) begin
        nxt_st.in_service_reg[pch] = 1'b1;
      end
    end

    // State registers of one controller
    always_ff @(posedge clock) begin
      if (rst) begin
        st_ff        <= '0;
        st_ff.lowest <= `CCDIC_LOWEST_RST;
        st_ff.casc   <= (gi == 0) ? `CCDIC_MASTER_CASC : `CCDIC_SLAVE_ID_RST;
      end else begin
        st_ff <= nxt_st;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and vector drive

  logic [7:0] nxt_rdata;
  logic [7:0] nxt_periph_data;
  logic       nxt_periph_oe_n;

  // Read data stands one cycle; vector drives the bus one cycle
  always_comb begin
    nxt_rdata       = `CCDIC_UNMAPPED_RD;
    nxt_periph_data = periph_data_ff;
    nxt_periph_oe_n = 1'b1;
    if (io_req.rd && hit_w[0]) begin
      nxt_rdata = rd_w[0];
    end else if (io_req.rd && hit_w[1]) begin
      nxt_rdata = rd_w[1];
    end
    if (drive_w[1]) begin
      nxt_periph_data = vec_w[1];
      nxt_periph_oe_n = 1'b0;
    end else if (drive_w[0]) begin
      nxt_periph_data = vec_w[0];
      nxt_periph_oe_n = 1'b0;
    end
  end

  // Output registers
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff            <= `CCDIC_UNMAPPED_RD;
      periph_data_ff      <= `CCDIC_UNMAPPED_RD;
      periph_data_oe_n_ff <= 1'b1;
    end else begin
      rdata_ff            <= nxt_rdata;
      periph_data_ff      <= nxt_periph_data;
      periph_data_oe_n_ff <= nxt_periph_oe_n;
    end
  end

endmodule // ccdic_top

// [testbench/ccdic_assertions.sv]
// Port checker for the cascaded interrupt controller pair.
// Assumes the bind at the foot of this file; sees only top ports.
`timescale 1ns/10ps

module ccdic_chk (
  // Clock and reset
  input wire logic                     clock,
  input wire logic                     rst,
  // Register port
  input wire ccdic_pkg::ccdic_io_req_s io_req,
  input wire logic [7:0]               rdata_ff,
  // Request pins
  input wire logic                     timer0_output,
  input wire logic                     rtc_irq,
  input wire logic                     irq1,
  input wire logic [4:0]               irq3_7,
  input wire logic [6:0]               irq9_15,
  // Processor side
  input wire logic                     cpu_intr,
  input wire logic                     iack_first,
  input wire logic                     iack_second,
  input wire logic [7:0]               periph_data_ff,
  input wire logic                     periph_data_oe_n_ff
);
  logic [14:0] pins_ff;
  logic [5:0]  hist_ff;
  logic        spur_ff;
  logic        pend_ff;
  logic        chg;

  // Pin change history and acknowledge tracking
  assign chg = {irq9_15, rtc_irq, irq3_7, irq1, timer0_output} != pins_ff;
  always_ff @(posedge clock) begin
    pins_ff <= {irq9_15, rtc_irq, irq3_7, irq1, timer0_output};
    hist_ff <= {hist_ff[4:0], chg};
    spur_ff <= iack_first ? !cpu_intr : spur_ff;
    pend_ff <= !rst && (iack_first || (pend_ff && !iack_second));
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  rd_idle_a: assert property (
    !io_req.rd |=> rdata_ff == 8'h00) else $error("read data outside answer cycle");
  rd_unmapped_a: assert property (
    io_req.rd && !(io_req.addr inside {16'h0020, 16'h0021, 16'h00A0, 16'h00A1})
    |=> rdata_ff == 8'h00) else $error("unmapped read not zero");
  vec_pulse_a: assert property (
    !periph_data_oe_n_ff |=> periph_data_oe_n_ff) else $error("vector drive too long");
  vec_cause_a: assert property (
    $fell(periph_data_oe_n_ff) |-> $past(iack_second)) else $error("vector without ack");
  orphan_ack_a: assert property (
    iack_second && !pend_ff |=> periph_data_oe_n_ff) else $error("drive without first ack");
  spur_level_a: assert property (
    $fell(periph_data_oe_n_ff) && spur_ff |-> periph_data_ff[2:0] == 3'h7)
    else $error("spurious vector not level 7");
  intr_hold_a: assert property (
    $fell(cpu_intr) |-> $past(iack_first) || $past(io_req.wr) || $past(io_req.wr, 2)
    || (|hist_ff)) else $error("interrupt dropped without cause");
  intr_rise_a: assert property (
    $rose(cpu_intr) |-> $past(io_req.wr) || $past(io_req.wr, 2) || $past(iack_second)
    || $past(iack_second, 2) || (|hist_ff)) else $error("interrupt raised without cause");
endmodule // ccdic_chk

bind ccdic_top ccdic_chk i_ccdic_chk (
  .clock(clock), .rst(rst), .io_req(io_req), .rdata_ff(rdata_ff),
  .timer0_output(timer0_output), .rtc_irq(rtc_irq), .irq1(irq1), .irq3_7(irq3_7),
  .irq9_15(irq9_15), .cpu_intr(cpu_intr), .iack_first(iack_first),
  .iack_second(iack_second), .periph_data_ff(periph_data_ff),
  .periph_data_oe_n_ff(periph_data_oe_n_ff)
);

// [testbench/ccdic_cpu_model.sv]
// Processor model: runs two acknowledge cycles and takes the vector.
// Assumes start is a one-cycle pulse; gap sets the spacing of the two.
`timescale 1ns/10ps

module ccdic_cpu_model (
  // Clock, reset and command
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       start,
  input wire logic [3:0] gap,
  // Vector bus
  input wire logic [7:0] periph_data_ff,
  input wire logic       periph_data_oe_n_ff,
  // Acknowledge and result
  output logic           iack_first,
  output logic           iack_second,
  output logic [7:0]     vec,
  output logic           got
);
  logic [4:0] cnt;

  // First cycle, wait, second cycle, then capture while driven
  always @(posedge clock) begin
    if (rst) begin
      cnt         <= 5'h00;
      vec         <= 8'h00;
      iack_first  <= 1'b0;
      iack_second <= 1'b0;
      got         <= 1'b0;
    end else begin
      iack_first  <= start && (cnt == 5'h00);
      iack_second <= (cnt == 5'h01);
      got         <= !periph_data_oe_n_ff;
      if (start && cnt == 5'h00) begin
        cnt <= {1'b0, gap} + 5'h01;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
      if (!periph_data_oe_n_ff) begin
        vec <= periph_data_ff;
      end
    end
  end
endmodule // ccdic_cpu_model

// [testbench/cascaded_dual_interrupt_ctrl_test.sv]
// Self-checking bench of the cascaded interrupt controller pair.
// Assumes ccdic_top, the processor model and the bound checker.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end

module cascaded_dual_interrupt_ctrl_test;
  logic                     clock  = 1'b0;
  logic                     rst    = 1'b1;
  logic                     start  = 1'b0;
  logic [3:0]               gap    = 4'h0;
  logic [15:0]              pins   = 16'h0000;
  ccdic_pkg::ccdic_io_req_s io_req = '0;
  logic [7:0]               rdata_ff;
  logic [7:0]               periph_data_ff;
  logic [7:0]               vec;
  logic                     cpu_intr;
  logic                     iack_first;
  logic                     iack_second;
  logic                     periph_data_oe_n_ff;
  logic                     got;
  int                       err_total = 0;
  int                       n_tests   = 0;

  ccdic_top i_ccdic_top (
    .clock(clock), .rst(rst), .io_req(io_req), .rdata_ff(rdata_ff),
    .timer0_output(pins[0]), .rtc_irq(pins[8]), .irq1(pins[1]), .irq3_7(pins[7:3]),
    .irq9_15(pins[15:9]), .cpu_intr(cpu_intr), .iack_first(iack_first),
    .iack_second(iack_second), .periph_data_ff(periph_data_ff),
    .periph_data_oe_n_ff(periph_data_oe_n_ff)
  );
  ccdic_cpu_model i_ccdic_cpu_model (
    .clock(clock), .rst(rst), .start(start), .gap(gap), .periph_data_ff(periph_data_ff),
    .periph_data_oe_n_ff(periph_data_oe_n_ff), .iack_first(iack_first),
    .iack_second(iack_second), .vec(vec), .got(got)
  );

  // Clock and watchdog
  initial begin
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    summarize();
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock) io_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock) io_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge clock) io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock) io_req.rd <= 1'b0;
    #1 `CHK(n, e, rdata_ff)
  endtask
  task automatic pin(input int i, input logic v);
    @(posedge clock) pins[i] <= v;
    repeat (4) @(posedge clock);
    #1;
  endtask
  task automatic ack(input logic [7:0] e, input string n);
    int k;
    @(posedge clock) start <= 1'b1;
    @(posedge clock) start <= 1'b0;
    for (k = 0; k < 40 && got !== 1'b1; k++) @(posedge clock) #1;
    `CHK("answer", 1'b1, got)
    `CHK(n, e, vec)
  endtask
  task automatic init(input logic [7:0] mode);
    wr(16'h0020, 8'h11);
    wr(16'h0021, 8'h08);
    wr(16'h0021, 8'h04);
    wr(16'h0021, mode);
    wr(16'h00A0, 8'h11);
    wr(16'h00A1, 8'h70);
    wr(16'h00A1, 8'h02);
    wr(16'h00A1, 8'h01);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd(16'h0020, 8'h00, "pending");
    rd(16'h0021, 8'h00, "mask");
    wr(16'h0021, 8'hA5);
    wr(16'h0121, 8'hFF);
    rd(16'h0021, 8'hA5, "mask");
    rd(16'h0030, 8'h00, "unmapped");
    wr(16'h0021, 8'h08);
    pin(3, 1'b1);
    `CHK("masked", 1'b0, cpu_intr)
    wr(16'h0021, 8'h00);
    `CHK("unmasked", 1'b1, cpu_intr)
    ack(8'h0B, "vector");
    wr(16'h0020, 8'h20);
    pin(3, 1'b0);
  endtask
  task automatic t_channels;
    for (int i = 0; i < 16; i++) begin
      if (i != 2) begin
        pin(i, 1'b1);
        `CHK("request", 1'b1, cpu_intr)
        ack((i < 8 ? 8'h08 : 8'h70) | 8'(i % 8), "vector");
        if (i > 7) wr(16'h00A0, 8'h20);
        wr(16'h0020, 8'h20);
        pin(i, 1'b0);
      end
    end
  endtask
  task automatic t_nest;
    pin(5, 1'b1);
    pin(3, 1'b1);
    ack(8'h0B, "fixed order");
    rd(16'h0020, 8'h20, "pending");
    wr(16'h0020, 8'h0B);
    rd(16'h0020, 8'h08, "in-service");
    `CHK("inhibit", 1'b0, cpu_intr)
    pin(1, 1'b1);
    `CHK("nested", 1'b1, cpu_intr)
    ack(8'h09, "nested vector");
    wr(16'h0020, 8'h20);
    rd(16'h0020, 8'h08, "ns end");
    wr(16'h0020, 8'h63);
    ack(8'h0D, "next vector");
    wr(16'h0020, 8'h65);
    rd(16'h0020, 8'h00, "sp end");
    pin(1, 1'b0);
    pin(3, 1'b0);
    pin(5, 1'b0);
  endtask
  task automatic t_smm;
    pin(3, 1'b1);
    ack(8'h0B, "masked service");
    wr(16'h0021, 8'h08);
    wr(16'h0020, 8'h6B);
    wr(16'h0020, 8'h20);
    rd(16'h0020, 8'h08, "special mask");
    wr(16'h0020, 8'h4B);
    wr(16'h0020, 8'h20);
    rd(16'h0020, 8'h00, "normal mask");
    wr(16'h0021, 8'h00);
    pin(3, 1'b0);
  endtask
  task automatic t_rotate;
    wr(16'h0020, 8'hC5);
    pin(0, 1'b1);
    pin(6, 1'b1);
    ack(8'h0E, "rotated");
    wr(16'h0020, 8'h66);
    ack(8'h08, "after rotated");
    wr(16'h0020, 8'h60);
    wr(16'h0020, 8'hC7);
    pin(0, 1'b0);
    pin(6, 1'b0);
    gap <= 4'h3;
    ack(8'h0F, "spurious");
    gap <= 4'h0;
  endtask
  task automatic t_level;
    wr(16'h0020, 8'h19);
    wr(16'h0021, 8'h08);
    wr(16'h0021, 8'h04);
    wr(16'h0021, 8'h01);
    pin(5, 1'b1);
    ack(8'h0D, "level vector");
    `CHK("level held", 1'b0, cpu_intr)
    wr(16'h0020, 8'h65);
    `CHK("level again", 1'b1, cpu_intr)
    pin(5, 1'b0);
    `CHK("withdrawn", 1'b0, cpu_intr)
  endtask
  task automatic t_auto;
    init(8'h03);
    wr(16'h0020, 8'h80);
    pin(3, 1'b1);
    pin(4, 1'b1);
    ack(8'h0B, "auto end");
    wr(16'h0020, 8'h0B);
    rd(16'h0020, 8'h00, "auto cleared");
    pin(3, 1'b0);
    pin(3, 1'b1);
    ack(8'h0C, "auto rotate");
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    init(8'h01);
    t_regs();
    t_channels();
    t_nest();
    t_smm();
    t_rotate();
    t_level();
    t_auto();
    summarize();
  end
endmodule // cascaded_dual_interrupt_ctrl_test
